/* dpc_serial_slave.v */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.vh"
// Functional notes
// - Wiper position decodes to one-hot taps
// - Wiper: write, load from stored, read
// - Comparator enable, latch, shutdown control bits
// - Comparator control: write, load, read back
// - Upper address nibble must match type
// - Lower address nibble must match straps
// - No ack during nonvolatile write cycle
// - Instruction: opcode, index, unit fields
// - Four two-byte transfer instructions
// - Stored-to-volatile transfer, settle delay
// - Volatile-to-stored transfer is nonvolatile write
// - Global transfers move all four units
// - Four three-byte read/write instructions
// - Increment/decrement on each clock high
// - Read volatile: two zeros, six bits
// - Write volatile register from data byte
// - Read stored register by index, unit
// - Write stored register, program at stop
// - Copy stored register into volatile
// - Ack address, instruction and written data
// - Write protect low blocks nonvolatile writes
// - Power-up loads volatile from index zero
// - Control bits: power, buffer, latch
module dpc_serial_slave #(
   parameter DEV_TYPE   = 4'h0,                // Arbitrary type code, set per product
   parameter NVW_CYCLES = `DPC_NVW_CYCLES,
   parameter TAPS       = 64
) (
   input  wire              i_core_clk,
   input  wire              i_nrst,
   input  wire              i_scl,
   input  wire              i_sda,
   output reg               o_sda_oe,
   output reg               o_sda_out,
   input  wire [3:0]        i_address_strap_pins,
   input  wire              i_write_protect_n,
   input  wire [1:0]        i_cmp_raw,
   output reg  [1:0]        o_comparator_output_pin,
   output reg  [1:0]        o_comparator_output_oe,
   output reg  [1:0]        o_comparator_power,
   output reg  [5:0]        o_wiper_position_reg_0,
   output reg  [5:0]        o_wiper_position_reg_1,
   output reg  [5:0]        o_comparator_control_reg_0,
   output reg  [5:0]        o_comparator_control_reg_1,
   output wire [TAPS-1:0]   o_tap_sel_0,
   output wire [TAPS-1:0]   o_tap_sel_1,
   output reg               o_nv_busy
);
   // Phases of a transfer
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_ADDR = 7'h02;
   localparam [6:0] ST_INST = 7'h04;
   localparam [6:0] ST_WDAT = 7'h08;
   localparam [6:0] ST_RDAT = 7'h10;
   localparam [6:0] ST_STEP = 7'h20;
   localparam [6:0] ST_SKIP = 7'h40;
   localparam [31:0] SETTLE = `DPC_SETTLE_CYCLES;
   localparam [31:0] NVW    = NVW_CYCLES;

   // Pin synchronisers: first stage read only by second
   reg  [1:0]  scl_sync;
   reg  [1:0]  sda_sync;
   reg  [3:0]  adr_s1;
   reg  [3:0]  adr_s2;
   reg         wp_s1;
   reg         wp_s2;
   reg  [1:0]  cmp_s1;                         // Comparator results, first stage
   reg  [1:0]  cmp_s2;                         // Comparator results, second stage
   reg         scl_d;                          // Delayed sync clock for edges
   reg         sda_d;                          // Delayed sync data for start/stop
   wire        scl = scl_sync[1];
   wire        sda = sda_sync[1];
   wire        scl_rise = scl & ~scl_d;
   wire        scl_fall = ~scl & scl_d;
   wire        start_c  = scl & scl_d & sda_d & ~sda;
   wire        stop_c   = scl & scl_d & ~sda_d & sda;

   // Register storage
   reg  [5:0]  vol [0:3];                      // Wiper 0/1, comparator 0/1
   reg  [5:0]  nvm [0:15];                     // Stored settings, unit*4+index
   reg  [6:0]  state;
   reg  [7:0]  shreg;                          // Incoming byte
   reg  [7:0]  txreg;                          // Outgoing byte
   reg  [3:0]  bitcnt;                         // Bit 8 is the ack slot
   reg  [7:0]  inst;                           // Latched instruction
   reg  [5:0]  wdata;                          // Pending stored-write data
   reg         nv_pend;                        // Nonvolatile write armed for stop
   reg  [31:0] nv_cnt;                         // Nonvolatile write timer
   reg         init_done;                      // Power-up recall finished
   reg  [31:0] settle_cnt;                     // Wiper settle timer
   reg  [5:0]  wip_pend_0;
   reg  [5:0]  wip_pend_1;
   reg  [1:0]  cmp_latched;
   integer     k;

   wire [3:0]  opc  = inst[`DPC_OPC_HI:`DPC_OPC_LO];
   wire [1:0]  ridx = inst[`DPC_RIDX_HI:`DPC_RIDX_LO];
   wire [1:0]  unit = inst[`DPC_UNIT_HI:`DPC_UNIT_LO];
   wire [7:0]  rx   = {shreg[6:0], sda};       // Byte including the eighth bit

   // Synchronise all pins twice
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         adr_s1   <= 4'h0;
         adr_s2   <= 4'h0;
         wp_s1    <= 1'b0;
         wp_s2    <= 1'b0;
         cmp_s1   <= 2'h0;
         cmp_s2   <= 2'h0;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], i_scl};
         sda_sync <= {sda_sync[0], i_sda};
         adr_s1   <= i_address_strap_pins;
         adr_s2   <= adr_s1;
         wp_s1    <= i_write_protect_n;
         wp_s2    <= wp_s1;
         cmp_s1   <= i_cmp_raw;
         cmp_s2   <= cmp_s1;
         scl_d    <= scl;
         sda_d    <= sda;
      end
   end

   // Protocol engine, register file and timers
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state      <= ST_IDLE;
         shreg      <= 8'h00;
         txreg      <= 8'h00;
         bitcnt     <= 4'h0;
         inst       <= 8'h00;
         wdata      <= 6'h00;
         nv_pend    <= 1'b0;
         nv_cnt     <= 32'h0;
         init_done  <= 1'b0;
         o_sda_oe   <= 1'b0;
         o_sda_out  <= 1'b0;
         o_nv_busy  <= 1'b0;
         for (k = 0; k < 4; k = k + 1) begin
            vol[k] <= `DPC_RST_DATA;
         end
         for (k = 0; k < 16; k = k + 1) begin
            nvm[k] <= `DPC_RST_DATA;
         end
      end else if (!init_done) begin
         for (k = 0; k < 4; k = k + 1) begin
            vol[k] <= nvm[k*4];
         end
         init_done <= 1'b1;
      end else begin
         // Nonvolatile write timer
         if (nv_cnt != 32'h0) begin
            nv_cnt <= nv_cnt - 32'h1;
         end
         o_nv_busy <= (nv_cnt > 32'h1);
         if (start_c) begin
            // Any start reopens addressing; the clock fall that ends
            // the start is no bit, so the count sits one below zero
            state    <= ST_ADDR;
            bitcnt   <= 4'hf;
            o_sda_oe <= 1'b0;
            nv_pend  <= 1'b0;
         end else if (stop_c) begin
            state    <= ST_IDLE;
            o_sda_oe <= 1'b0;
            if (nv_pend) begin
               nv_pend <= 1'b0;
               nv_cnt  <= NVW;
               o_nv_busy <= 1'b1;
               if (opc == `DPC_OP_XFR_V2DR) begin
                  nvm[{unit, ridx}] <= vol[unit];
               end else if (opc == `DPC_OP_GXFR_V2DR) begin
                  for (k = 0; k < 4; k = k + 1) begin
                     nvm[k*4 + ridx] <= vol[k];
                  end
               end else begin
                  nvm[{unit, ridx}] <= wdata;
               end
            end
         end else begin
            case (state)
               ST_ADDR, ST_INST, ST_WDAT: begin
                  if (scl_rise && bitcnt < 4'h8) begin
                     shreg  <= rx;
                  end
                  if (scl_fall) begin
                     if (bitcnt == 4'h7) begin
                        // Eighth bit done: decide ack
                        bitcnt <= 4'h8;
                        if (state == ST_ADDR) begin
                           if (shreg[`DPC_DEV_TYPE_HI:`DPC_DEV_TYPE_LO] == DEV_TYPE &&
                               shreg[3:0] == adr_s2 && nv_cnt == 32'h0) begin
                              o_sda_oe  <= 1'b1;
                              o_sda_out <= 1'b0;
                           end else begin
                              state <= ST_SKIP;
                           end
                        end else begin
                           o_sda_oe  <= 1'b1;
                           o_sda_out <= 1'b0;
                        end
                     end else if (bitcnt == 4'h8) begin
                        // Ack slot over: act on byte
                        o_sda_oe <= 1'b0;
                        bitcnt   <= 4'h0;
                        if (state == ST_ADDR) begin
                           state <= ST_INST;
                        end else if (state == ST_INST) begin
                           inst <= shreg;
                           case (shreg[`DPC_OPC_HI:`DPC_OPC_LO])
                              `DPC_OP_RD_VOL: begin
                                 txreg <= {2'b00, vol[shreg[1:0]]};
                                 state <= ST_RDAT;
                                 // Two leading zeros: first bit drives low
                                 o_sda_oe  <= 1'b1;
                                 o_sda_out <= 1'b0;
                              end
                              `DPC_OP_RD_DR: begin
                                 txreg <= {2'b00, nvm[{shreg[1:0], shreg[3:2]}]};
                                 state <= ST_RDAT;
                                 o_sda_oe  <= 1'b1;
                                 o_sda_out <= 1'b0;
                              end
                              `DPC_OP_WR_VOL, `DPC_OP_WR_DR: begin
                                 state <= ST_WDAT;
                              end
                              `DPC_OP_INCDEC: begin
                                 state <= ST_STEP;
                              end
                              `DPC_OP_XFR_DR2V: begin
                                 vol[shreg[1:0]] <= nvm[{shreg[1:0], shreg[3:2]}];
                                 state <= ST_SKIP;
                              end
                              `DPC_OP_GXFR_DR2V: begin
                                 for (k = 0; k < 4; k = k + 1) begin
                                    vol[k] <= nvm[k*4 + shreg[3:2]];
                                 end
                                 state <= ST_SKIP;
                              end
                              `DPC_OP_XFR_V2DR, `DPC_OP_GXFR_V2DR: begin
                                 nv_pend <= wp_s2;
                                 state   <= ST_SKIP;
                              end
                              default: begin
                                 state <= ST_SKIP;
                              end
                           endcase
                        end else begin
                           if (opc == `DPC_OP_WR_VOL) begin
                              vol[unit] <= shreg[5:0];
                           end else begin
                              wdata   <= shreg[5:0];
                              nv_pend <= wp_s2;
                           end
                           state <= ST_SKIP;
                        end
                     end else begin
                        bitcnt <= bitcnt + 4'h1;
                     end
                  end
               end
               ST_RDAT: begin
                  // Shift out on falls, release for master ack
                  if (scl_fall) begin
                     if (bitcnt == 4'h7) begin
                        o_sda_oe <= 1'b0;
                        state    <= ST_SKIP;
                     end else begin
                        bitcnt    <= bitcnt + 4'h1;
                        o_sda_oe  <= ~txreg[6 - bitcnt[2:0]];
                        o_sda_out <= 1'b0;
                     end
                  end
               end
               ST_STEP: begin
                  // step per high pulse
                  // Counted when the high pulse ends: the stop's high never
                  // ends, so closing the frame adds no stray step
                  if (scl_fall && !unit[1]) begin
                     if (sda && vol[unit] != `DPC_TAP_MAX) begin
                        vol[unit] <= vol[unit] + 6'h01;
                     end else if (!sda && vol[unit] != `DPC_TAP_MIN) begin
                        vol[unit] <= vol[unit] - 6'h01;
                     end
                  end
               end
               ST_SKIP: begin
                  o_sda_oe <= 1'b0;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         settle_cnt <= 32'h0;
         wip_pend_0 <= `DPC_RST_DATA;
         wip_pend_1 <= `DPC_RST_DATA;
         o_wiper_position_reg_0 <= `DPC_RST_DATA;
         o_wiper_position_reg_1 <= `DPC_RST_DATA;
      end else begin
         if (vol[0] != wip_pend_0 || vol[1] != wip_pend_1) begin
            wip_pend_0 <= vol[0];
            wip_pend_1 <= vol[1];
            settle_cnt <= SETTLE;
         end else if (settle_cnt != 32'h0) begin
            settle_cnt <= settle_cnt - 32'h1;
         end else begin
            o_wiper_position_reg_0 <= wip_pend_0;
            o_wiper_position_reg_1 <= wip_pend_1;
         end
      end
   end

   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cmp_latched <= 2'h0;
         o_comparator_output_pin    <= 2'h0;
         o_comparator_output_oe     <= 2'h0;
         o_comparator_power         <= 2'h0;
         o_comparator_control_reg_0 <= `DPC_RST_DATA;
         o_comparator_control_reg_1 <= `DPC_RST_DATA;
      end else begin
         o_comparator_control_reg_0 <= vol[2];
         o_comparator_control_reg_1 <= vol[3];
         for (k = 0; k < 2; k = k + 1) begin
            o_comparator_power[k]     <= vol[k+2][`DPC_CMP_PWR_BIT];
            o_comparator_output_oe[k] <= vol[k+2][`DPC_CMP_EN_BIT];
            if (!vol[k+2][`DPC_CMP_LATCH_BIT]) begin
               cmp_latched[k] <= cmp_s2[k] & vol[k+2][`DPC_CMP_PWR_BIT];
            end
            o_comparator_output_pin[k] <= cmp_latched[k];
         end
      end
   end

   dpc_tap_decode #(.TAPS(TAPS)) u_dec0 (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_pos      (o_wiper_position_reg_0),
      .o_tap      (o_tap_sel_0)
   );
   dpc_tap_decode #(.TAPS(TAPS)) u_dec1 (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_pos      (o_wiper_position_reg_1),
      .o_tap      (o_tap_sel_1)
   );
endmodule
`default_nettype wire

/* dpc_map.vh */
`ifndef DPC_MAP_VH
`define DPC_MAP_VH
// Slave address fields
`define DPC_DEV_TYPE_HI      7
`define DPC_DEV_TYPE_LO      4
// Instruction byte fields
`define DPC_OPC_HI           7
`define DPC_OPC_LO           4
`define DPC_RIDX_HI          3
`define DPC_RIDX_LO          2
`define DPC_UNIT_HI          1
`define DPC_UNIT_LO          0
// Opcodes
`define DPC_OP_GXFR_DR2V     4'h1
`define DPC_OP_INCDEC        4'h2
`define DPC_OP_GXFR_V2DR     4'h8
`define DPC_OP_RD_VOL        4'h9
`define DPC_OP_WR_VOL        4'ha
`define DPC_OP_RD_DR         4'hb
`define DPC_OP_WR_DR         4'hc
`define DPC_OP_XFR_DR2V      4'hd
`define DPC_OP_XFR_V2DR      4'he
// Comparator control bit positions
`define DPC_CMP_PWR_BIT      0
`define DPC_CMP_EN_BIT       1
`define DPC_CMP_LATCH_BIT    2
// Reset value and wiper step limits
`define DPC_RST_DATA         6'h00
`define DPC_TAP_MAX          6'h3f
`define DPC_TAP_MIN          6'h00
// Timing: nonvolatile write in us, settle in ns, core clock in MHz
`define DPC_CLK_MHZ          100
`define DPC_NVW_TIME_US      5000
`define DPC_NVW_CYCLES       (`DPC_NVW_TIME_US * `DPC_CLK_MHZ)
`define DPC_SETTLE_TIME_NS   500
`define DPC_SETTLE_CYCLES    ((`DPC_SETTLE_TIME_NS * `DPC_CLK_MHZ) / 1000)
`endif

/* dpc_tap_decode.v */
`timescale 1ns/1ps
`default_nettype none
// One-hot tap switch decoder for one array
module dpc_tap_decode #(
   parameter TAPS = 64
) (
   input  wire        i_core_clk,
   input  wire        i_nrst,
   input  wire [5:0]  i_pos,
   output reg  [TAPS-1:0] o_tap
);
   genvar g;
   // One switch per tap, registered so the pin side never glitches
   generate
      for (g = 0; g < TAPS; g = g + 1) begin : g_tap
         always @(posedge i_core_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               o_tap[g] <= (g == 0);
            end else begin
               o_tap[g] <= (i_pos == g);
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* dpc_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the serial slave
module dpc_props #(
   parameter NVW_CYCLES = 200,
   parameter TAPS       = 64
) (
   input wire logic            i_core_clk,
   input wire logic            i_nrst,
   input wire logic            o_sda_oe,
   input wire logic            o_sda_out,
   input wire logic            i_write_protect_n,
   input wire logic [1:0]      o_comparator_output_pin,
   input wire logic [1:0]      o_comparator_output_oe,
   input wire logic [1:0]      o_comparator_power,
   input wire logic [5:0]      o_wiper_position_reg_0,
   input wire logic [5:0]      o_comparator_control_reg_0,
   input wire logic [TAPS-1:0] o_tap_sel_0,
   input wire logic [TAPS-1:0] o_tap_sel_1,
   input wire logic            o_nv_busy
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   logic [31:0] busy_len;   // Cycles spent in the current write cycle
   // Counter restarts whenever the write cycle is idle
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         busy_len <= 32'h0;
      end else if (o_nv_busy) begin
         busy_len <= busy_len + 32'h1;
      end else begin
         busy_len <= 32'h0;
      end
   end
   // Settled wiper selects exactly its own tap
   property p_tap_follow;
      $stable(o_wiper_position_reg_0) [*4] |->
         $onehot(o_tap_sel_0) && o_tap_sel_0[o_wiper_position_reg_0];
   endproperty
   a_tap_follow: assert property (p_tap_follow) else $error("tap 0 mismatch");
   property p_tap1_onehot;
      $onehot(o_tap_sel_1);
   endproperty
   a_tap1_onehot: assert property (p_tap1_onehot) else $error("tap 1 not one-hot");
   // Power and buffer follow their control bits once settled
   property p_cmp_ctrl;
      $stable(o_comparator_control_reg_0) [*3] |->
         o_comparator_power[0] == o_comparator_control_reg_0[0] &&
         o_comparator_output_oe[0] == o_comparator_control_reg_0[1];
   endproperty
   a_cmp_ctrl: assert property (p_cmp_ctrl) else $error("comparator control");
   // Latched output must not move
   property p_latch_hold;
      ($stable(o_comparator_control_reg_0) && o_comparator_control_reg_0[2]) [*4]
         |-> $stable(o_comparator_output_pin[0]);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latched output moved");
   property p_sda_low;
      o_sda_oe |-> !o_sda_out;
   endproperty
   a_sda_low: assert property (p_sda_low) else $error("data line driven high");
   // No answer on the bus deep inside a write cycle
   property p_busy_quiet;
      o_nv_busy [*8] |-> !o_sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
   property p_nvw_min;
      $fell(o_nv_busy) |-> busy_len >= NVW_CYCLES - 2;
   endproperty
   a_nvw_min: assert property (p_nvw_min) else $error("write cycle too short");
   property p_nvw_max;
      o_nv_busy |-> busy_len < NVW_CYCLES + 16;
   endproperty
   a_nvw_max: assert property (p_nvw_max) else $error("write cycle too long");
   property p_wp_block;
      $rose(o_nv_busy) |-> $past(i_write_protect_n, 2);
   endproperty
   a_wp_block: assert property (p_wp_block) else $error("write while protected");
endmodule
bind dpc_serial_slave dpc_props #(.NVW_CYCLES(NVW_CYCLES), .TAPS(TAPS)) u_props (
   .i_core_clk(i_core_clk), .i_nrst(i_nrst), .o_sda_oe(o_sda_oe),
   .o_sda_out(o_sda_out), .i_write_protect_n(i_write_protect_n),
   .o_comparator_output_pin(o_comparator_output_pin),
   .o_comparator_output_oe(o_comparator_output_oe),
   .o_comparator_power(o_comparator_power),
   .o_wiper_position_reg_0(o_wiper_position_reg_0),
   .o_comparator_control_reg_0(o_comparator_control_reg_0),
   .o_tap_sel_0(o_tap_sel_0), .o_tap_sel_1(o_tap_sel_1), .o_nv_busy(o_nv_busy));
`default_nettype wire

/* dpc_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus master; bus clock stands high between frames
module dpc_bus_master (
   input  wire logic i_core_clk,
   input  wire logic i_sda,   // Resolved line, pulled up
   output var  logic o_scl,
   output var  logic o_sda    // 1 releases the line
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // Moves land just after a core clock edge
   task automatic w(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   // One bit; data only moves while the clock is low
   task automatic bit_slot(input logic b, output logic r);
      o_sda = b;
      w(2);
      o_scl = 1'b1;
      w(3);
      r = i_sda;
      w(1);
      o_scl = 1'b0;
      w(2);
   endtask
   task automatic start_cond();
      o_sda = 1'b1;
      w(2);
      o_scl = 1'b1;
      w(4);
      o_sda = 1'b0;
      w(4);
      o_scl = 1'b0;
      w(2);
   endtask
   task automatic stop_cond();
      o_sda = 1'b0;
      w(2);
      o_scl = 1'b1;
      w(4);
      o_sda = 1'b1;
      w(8);
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
      bit_slot(1'b1, r);
      ack = !r;
   endtask
   task automatic get_byte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, r);
         d[i] = r;
      end
      bit_slot(1'b0, r);
   endtask
   // pulses, stop ends
   // Kind 0 two-byte, 1 write, 2 read, 3 step (d[7] up, d[3:0] pulses)
   task automatic cmd(input logic [7:0] a, input logic [7:0] ins, input logic [7:0] d,
                      input int kind, output logic [2:0] acks, output logic [7:0] rd);
      logic r;
      acks = 3'h0;
      rd = 8'h00;
      start_cond();
      send_byte(a, acks[2]);
      if (acks[2]) begin
         send_byte(ins, acks[1]);
         if (kind == 1) send_byte(d, acks[0]);
         if (kind == 2) get_byte(rd);
         if (kind == 3) for (int i = 0; i < d[3:0]; i++) bit_slot(d[7], r);
      end
      stop_cond();
   endtask
   task automatic poll(input logic [7:0] a, output int n);
      logic ack;
      n = 0;
      ack = 1'b0;
      while (!ack && n < 40) begin
         n++;
         start_cond();
         send_byte(a, ack);
         stop_cond();
      end
   endtask
endmodule
`default_nettype wire

/* dual_pot_serial_command_slave_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_pot_serial_command_slave_tb_top;
   localparam logic [3:0] TYPE_ID = 4'h6;   // Arbitrary type code
   localparam logic [3:0] STRAP   = 4'h9;
   localparam logic [7:0] ADDR    = {TYPE_ID, STRAP};
   logic        i_core_clk, i_nrst, i_write_protect_n;
   logic [1:0]  i_cmp_raw;
   logic [3:0]  strap;
   logic        m_scl, m_sda, sda_oe, sda_out, busy;
   wire         sda_line = m_sda & (~sda_oe | sda_out);   // Pull-up wins when released
   logic [1:0]  cmp_pin, cmp_oe, cmp_pwr;
   logic [5:0]  w0, w1, c0, c1;
   logic [63:0] t0, t1;
   int          err_count, n_checks;
   logic [2:0]  a;
   logic [7:0]  rd;
   int          n;
   dpc_bus_master m (.i_core_clk(i_core_clk), .i_sda(sda_line), .o_scl(m_scl), .o_sda(m_sda));
   dpc_serial_slave #(.DEV_TYPE(TYPE_ID), .NVW_CYCLES(200)) uut (
      .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_scl(m_scl), .i_sda(sda_line),
      .o_sda_oe(sda_oe), .o_sda_out(sda_out), .i_address_strap_pins(strap),
      .i_write_protect_n(i_write_protect_n), .i_cmp_raw(i_cmp_raw),
      .o_comparator_output_pin(cmp_pin), .o_comparator_output_oe(cmp_oe),
      .o_comparator_power(cmp_pwr), .o_wiper_position_reg_0(w0),
      .o_wiper_position_reg_1(w1), .o_comparator_control_reg_0(c0),
      .o_comparator_control_reg_1(c1), .o_tap_sel_0(t0), .o_tap_sel_1(t1), .o_nv_busy(busy));
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_reset();
      check({w0, w1, c0, c1}, 24'h0);
      check(t0 | t1, 64'h1);
   endtask
   // Every unit written, read back, outputs decoded
   task automatic t_volatile();
      for (int u = 0; u < 4; u++) begin
         m.cmd(ADDR, {4'ha, 2'b00, u[1:0]}, 8'h05 + 8'(u * 8), 1, a, rd);
         check(a, 3'b111);
      end
      m.w(60);
      check({w0, w1, c0, c1}, {6'h05, 6'h0d, 6'h15, 6'h1d});
      check(t1, 64'h1 << 13);
      check({cmp_pwr, cmp_oe}, 4'b1100);
      for (int u = 0; u < 4; u++) begin
         m.cmd(ADDR, {4'h9, 2'b00, u[1:0]}, 8'h00, 2, a, rd);
         check(rd, 8'h05 + 8'(u * 8));
      end
      m.cmd(ADDR, 8'ha2, 8'h02, 1, a, rd);
      m.w(60);
      check({cmp_pwr, cmp_oe}, 4'b1001);
      check(cmp_pin, 2'b00);
   endtask
   // Wrong type, then each strap bit wrong
   task automatic t_addr();
      m.cmd({~TYPE_ID, STRAP}, 8'ha0, 8'h3f, 1, a, rd);
      check(a, 3'b000);
      for (int b = 0; b < 4; b++) begin
         m.cmd({TYPE_ID, STRAP ^ (4'h1 << b)}, 8'ha0, 8'h3f, 1, a, rd);
         check(a, 3'b000);
      end
      strap = STRAP ^ 4'h8;
      m.cmd(ADDR, 8'ha0, 8'h3f, 1, a, rd);
      check(a, 3'b000);
      strap = STRAP;
      m.w(60);
      check(w0, 6'h05);
   endtask
   // Stored writes, polling, transfers both ways
   task automatic t_store();
      m.cmd(ADDR, 8'hc4, 8'h15, 1, a, rd);
      check(a, 3'b111);
      check(busy, 1'b1);
      m.poll(ADDR, n);
      check(n > 1, 1'b1);
      check(busy, 1'b0);
      m.cmd(ADDR, 8'hb4, 8'h00, 2, a, rd);
      check(rd, 8'h15);
      m.cmd(ADDR, 8'hd4, 8'h00, 0, a, rd);
      m.w(60);
      check(w0, 6'h15);
      m.cmd(ADDR, 8'he9, 8'h00, 0, a, rd);
      m.poll(ADDR, n);
      check(n > 1, 1'b1);
      m.cmd(ADDR, 8'hb9, 8'h00, 2, a, rd);
      check(rd, 8'h0d);
   endtask
   // Protected store must neither start nor change data
   task automatic t_protect();
      i_write_protect_n = 1'b0;
      m.cmd(ADDR, 8'hcf, 8'h2c, 1, a, rd);
      m.poll(ADDR, n);
      check(n, 1);
      m.cmd(ADDR, 8'hbf, 8'h00, 2, a, rd);
      check(rd, 8'h00);
      i_write_protect_n = 1'b1;
   endtask
   // Global store into index 3, global load from index 1
   task automatic t_global();
      logic [5:0] ev [4];
      ev = '{6'h15, 6'h0d, 6'h02, 6'h1d};
      m.cmd(ADDR, 8'h8c, 8'h00, 0, a, rd);
      m.poll(ADDR, n);
      for (int u = 0; u < 4; u++) begin
         m.cmd(ADDR, {4'hb, 2'b11, u[1:0]}, 8'h00, 2, a, rd);
         check(rd, {2'b00, ev[u]});
      end
      m.cmd(ADDR, 8'h14, 8'h00, 0, a, rd);
      m.w(60);
      check({w0, w1, c0, c1}, {6'h15, 18'h0});
   endtask
   task automatic step_case(input logic [7:0] s, input logic [7:0] d, input logic [5:0] e);
      m.cmd(ADDR, 8'ha0, s, 1, a, rd);
      m.cmd(ADDR, 8'h20, d, 3, a, rd);
      m.w(60);
      check(w0, e);
   endtask
   // Stepping up, down, and into both ends
   task automatic t_step();
      step_case(8'h3d, 8'h84, 6'h3f);
      step_case(8'h3d, 8'h02, 6'h3b);
      step_case(8'h01, 8'h03, 6'h00);
   endtask
   // Raw comparator result keeps moving
   always begin
      m.w(13);
      i_cmp_raw = i_cmp_raw + 2'h1;
   end
   // Hang guard well past the expected run
   initial begin
      repeat (60000) @(posedge i_core_clk);
      err_count++;
      give_verdict();
   end
   initial begin
      i_nrst = 1'b0;
      i_write_protect_n = 1'b1;
      i_cmp_raw = 2'h0;
      strap = STRAP;
      err_count = 0;
      n_checks = 0;
      repeat (10) @(posedge i_core_clk);
      #1;
      i_nrst = 1'b1;
      m.w(6);
      t_reset();
      t_volatile();
      t_addr();
      t_store();
      t_protect();
      t_global();
      t_step();
      give_verdict();
   end
endmodule
`default_nettype wire
